// file: mmoc_pkg.sv
// Package for the MAC operating-mode and interrupt-enable register bank.
// Assumes a 32-bit classic Wishbone slave on core_clk.
package mmoc_pkg;
    localparam logic [7:0] OPMODE_OFFSET = 8'h30;
    localparam logic [7:0] INTEN_OFFSET = 8'h38;
    localparam logic [7:0] PROC_OFFSET = 8'h3C;
    localparam logic [31:0] OPMODE_RESET = 32'h32000040;
    localparam logic [31:0] INTEN_RESET = 32'h00000000;
    localparam logic [31:0] INTEN_MASK = 32'h0001EFEF;
    localparam logic [31:0] OPMODE_RO_MASK = 32'h00000015;
    localparam logic [31:0] NORMAL_SRC_MASK = 32'h00004845;
    localparam logic [31:0] ABNORMAL_SRC_MASK = 32'h000027BA;
    localparam int HASH_SELECT_BIT = 0;
    localparam int RECEIVE_RUN_BIT = 1;
    localparam int HASH_ONLY_BIT = 2;
    localparam int KEEP_BAD_BIT = 3;
    localparam int INVERSE_BIT = 4;
    localparam int BACKOFF_HOLD_BIT = 5;
    localparam int ACCEPT_ANY_BIT = 6;
    localparam int PASS_MCAST_BIT = 7;
    localparam int LOOPBACK_LO_BIT = 10;
    localparam int THRESHOLD_LO_BIT = 14;
    localparam int ABNORMAL_SUM_BIT = 15;
    localparam int NORMAL_SUM_BIT = 16;
    localparam int PORT_SELECT_BIT = 18;
    localparam int STORE_FORWARD_BIT = 21;
    localparam int SLOW_THRESHOLD_BIT = 22;
    localparam int CODING_BIT = 23;
    localparam int RANDOMIZER_BIT = 24;
    localparam int RECEIVE_ALL_BIT = 30;
    localparam int IFS_10M_NS = 9600;
    localparam int IFS_100M_NS = 960;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [11:0] IFS_10M_CYCLES =
        12'((IFS_10M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] IFS_100M_CYCLES =
        12'((IFS_100M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [10:0] THR_SLOW_0 = 11'd72;
    localparam logic [10:0] THR_SLOW_1 = 11'd96;
    localparam logic [10:0] THR_SLOW_2 = 11'd128;
    localparam logic [10:0] THR_SLOW_3 = 11'd160;
    localparam logic [10:0] THR_FAST_0 = 11'd128;
    localparam logic [10:0] THR_FAST_1 = 11'd256;
    localparam logic [10:0] THR_FAST_2 = 11'd512;
    localparam logic [10:0] THR_FAST_3 = 11'd1024;
    localparam logic [2:0] RX_STATE_STOPPED = 3'h0;
    localparam logic [2:0] RX_STATE_FETCH = 3'h1;
    localparam logic [2:0] RX_STATE_WAIT = 3'h3;
    localparam logic [2:0] RX_STATE_SUSPENDED = 3'h4;

    typedef enum logic [2:0] {
        MMOC_FILT_PERFECT16,
        MMOC_FILT_HASH_ONE,
        MMOC_FILT_HASH_ALL,
        MMOC_FILT_INVERSE,
        MMOC_FILT_PROMISC,
        MMOC_FILT_ALL_MCAST,
        MMOC_FILT_UNDEFINED
    } mmoc_filter_t;

    typedef enum logic [1:0] {
        MMOC_PORT_SERIAL,
        MMOC_PORT_MII,
        MMOC_PORT_SYMBOL
    } mmoc_port_t;

    typedef struct packed {
        logic [3:0] match;
        logic is_multicast;
        logic valid;
    } mmoc_frame_t;

    typedef struct packed {
        logic accept;
        logic address_match;
    } mmoc_verdict_t;

    typedef struct packed {
        mmoc_port_t port;
        logic rate_100m;
        logic coding_on;
        logic randomizer_on;
        logic loop_internal;
        logic loop_external;
        logic mii_txen_block;
    } mmoc_port_cfg_t;
endpackage : mmoc_pkg

// file: mmoc_regs.sv
// Operating-mode and interrupt-enable registers with filter and port decode.
// Assumes a classic Wishbone master, and receive/backoff logic outside.
// Summary of operation
// RULE1 - Pass-multicast accepts every group-address frame; physical ones stay filtered.
// RULE2 - Accept-any receives every valid frame; it is set after reset.
// RULE3 - Backoff-hold pauses backoff on carrier; inter-frame gap after carrier drop.
// RULE4 - Inverse-filter bit is read only, meaningful under perfect filtering.
// RULE5 - Keep-bad-frames delivers runts, fragments and truncated frames that matched.
// RULE6 - Software wanting bad frames sets accept-any together with keep-bad-frames.
// RULE7 - Hash-only bit is read only; hashes physical and multicast addresses.
// RULE8 - Receive-run start fetches descriptor; not owned means suspend and flag.
// RULE9 - Software starts receive only when stopped and after list base is set.
// RULE10 - Clearing receive-run stops after current frame, only from running or suspended.
// RULE11 - Hash-select read only: clear is perfect, set hashes multicast.
// RULE12 - Threshold code picks 72..160 or 128..1024 bytes; store-forward overrides.
// RULE13 - Port select and slow threshold pick serial, MII 10 or MII 100.
// RULE14 - Coding bit at 100 Mb/s gives symbol mode; randomizer adds scrambling.
// RULE15 - Loopback field: 00 normal, 01 internal, 10 external.
// RULE16 - Internal loopback covers both ports; MII transmit enable held off.
// RULE17 - Filter bits decode to perfect, hash, inverse, promiscuous or all-multicast.
// RULE18 - Receive-all still evaluates the filter and reports address match.
// RULE19 - Software changes mode bits only while the named processes are stopped.
// RULE20 - An interrupt-enable bit set to one enables its status event.
// RULE21 - Hardware and software reset clear every interrupt enable.
// RULE22 - A source interrupts only with own enable, group summary and status set.
// RULE23 - Writes leave the read-only filter bits; setup frame establishes them.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mmoc_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic soft_rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic setup_load,
    input wire logic [2:0] setup_filter_bits,
    input wire logic desc_fetch_done,
    input wire logic desc_owned,
    input wire logic rx_frame_active,
    input wire mmoc_pkg::mmoc_frame_t frame_in,
    output mmoc_pkg::mmoc_verdict_t verdict,
    input wire logic carrier_sense,
    output logic backoff_run,
    output logic tx_gap_done,
    output logic rx_buf_unavail_set,
    output logic [2:0] rx_state,
    output logic [10:0] tx_threshold_bytes,
    output logic tx_store_forward,
    output mmoc_pkg::mmoc_port_cfg_t port_cfg,
    output logic keep_bad_frames,
    input wire logic [16:0] status_bits,
    output logic [16:0] int_pending
);
    typedef enum logic [1:0] {RX_STOPPED, RX_FETCH, RX_WAIT, RX_SUSP} rx_t;
    logic [31:0] opmode_r;
    logic [31:0] inten_r;
    logic [2:0] filt_r;
    logic ack_r;
    logic [31:0] dat_r;
    rx_t rx_r;
    logic stop_pending_r;
    logic [11:0] gap_cnt_r;
    logic carrier_seen_r;
    logic wr_stb;
    logic [31:0] wmask;
    logic [31:0] opmode_nxt;
    logic [31:0] opmode_view;
    mmoc_pkg::mmoc_filter_t filter_mode;

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : byte_mask

    assign wr_stb = cyc_i && stb_i && we_i && !ack_r && clk_en;
    assign wmask = byte_mask(sel_i);
    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // Read-only filter bits come from the setup-frame image, not the bus
    always_comb begin
        opmode_view = opmode_r & ~mmoc_pkg::OPMODE_RO_MASK; // RULE23
        opmode_view[mmoc_pkg::HASH_SELECT_BIT] = filt_r[0]; // RULE11
        opmode_view[mmoc_pkg::HASH_ONLY_BIT] = filt_r[1]; // RULE7
        opmode_view[mmoc_pkg::INVERSE_BIT] = filt_r[2]; // RULE4
    end

    always_comb begin
        opmode_nxt = (opmode_r & ~wmask) | (dat_i & wmask);
        opmode_nxt = opmode_nxt & ~mmoc_pkg::OPMODE_RO_MASK; // RULE23
    end

    // Single wait-free cycle: ack one edge after the strobe, then drop
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else if (clk_en) begin
            ack_r <= cyc_i && stb_i && !ack_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dat_r <= 32'h00000000;
        end else if (clk_en && cyc_i && stb_i && !ack_r) begin
            if (adr_i == mmoc_pkg::OPMODE_OFFSET) begin
                dat_r <= opmode_view;
            end else if (adr_i == mmoc_pkg::INTEN_OFFSET) begin
                dat_r <= inten_r;
            end else if (adr_i == mmoc_pkg::PROC_OFFSET) begin
                dat_r <= {29'h0000000, rx_state};
            end else begin
                dat_r <= 32'h00000000;
            end
        end
    end

    // Port select survives a software reset, the rest returns to reset value
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opmode_r <= mmoc_pkg::OPMODE_RESET & ~mmoc_pkg::OPMODE_RO_MASK; // RULE2
        end else if (clk_en) begin
            if (soft_rst) begin
                opmode_r <= (mmoc_pkg::OPMODE_RESET
                    & ~mmoc_pkg::OPMODE_RO_MASK & ~32'h00040000)
                    | (opmode_r & 32'h00040000);
            end else if (wr_stb && adr_i == mmoc_pkg::OPMODE_OFFSET) begin
                // Field-change timing is software's duty; no interlock here
                opmode_r <= opmode_nxt; // RULE19
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            filt_r <= 3'h0;
        end else if (clk_en) begin
            if (soft_rst) begin
                filt_r <= 3'h0;
            end else if (setup_load) begin
                filt_r <= setup_filter_bits; // RULE23
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inten_r <= mmoc_pkg::INTEN_RESET; // RULE21
        end else if (clk_en) begin
            if (soft_rst) begin
                inten_r <= mmoc_pkg::INTEN_RESET; // RULE21
            end else if (wr_stb && adr_i == mmoc_pkg::INTEN_OFFSET) begin
                inten_r <= ((inten_r & ~wmask) | (dat_i & wmask))
                    & mmoc_pkg::INTEN_MASK; // RULE20
            end
        end
    end

    // Each source needs own enable, its group summary enable and status
    always_comb begin
        int_pending = status_bits & inten_r[16:0]
            & ((mmoc_pkg::NORMAL_SRC_MASK[16:0]
                & {17{inten_r[mmoc_pkg::NORMAL_SUM_BIT]}})
             | (mmoc_pkg::ABNORMAL_SRC_MASK[16:0]
                & {17{inten_r[mmoc_pkg::ABNORMAL_SUM_BIT]}})); // RULE22
    end

    // Receive process control
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_r <= RX_STOPPED;
            stop_pending_r <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst) begin
                rx_r <= RX_STOPPED;
                stop_pending_r <= 1'b0;
            end else begin
                case (rx_r)
                    RX_STOPPED: begin
                        stop_pending_r <= 1'b0;
                        if (opmode_r[mmoc_pkg::RECEIVE_RUN_BIT]) begin
                            rx_r <= RX_FETCH; // RULE8
                        end
                    end
                    RX_FETCH: begin
                        if (desc_fetch_done) begin
                            rx_r <= desc_owned ? RX_WAIT : RX_SUSP; // RULE8
                        end
                    end
                    RX_WAIT, RX_SUSP: begin
                        if (!opmode_r[mmoc_pkg::RECEIVE_RUN_BIT]) begin
                            stop_pending_r <= 1'b1; // RULE10
                        end
                        if ((stop_pending_r
                             || !opmode_r[mmoc_pkg::RECEIVE_RUN_BIT])
                            && !rx_frame_active) begin
                            rx_r <= RX_STOPPED; // RULE10
                        end
                    end
                    default: rx_r <= RX_STOPPED;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_buf_unavail_set <= 1'b0;
        end else if (clk_en) begin
            rx_buf_unavail_set <= !soft_rst && rx_r == RX_FETCH
                && desc_fetch_done && !desc_owned; // RULE8
        end
    end

    always_comb begin
        case (rx_r)
            RX_STOPPED: rx_state = mmoc_pkg::RX_STATE_STOPPED;
            RX_FETCH: rx_state = mmoc_pkg::RX_STATE_FETCH;
            RX_WAIT: rx_state = mmoc_pkg::RX_STATE_WAIT;
            default: rx_state = mmoc_pkg::RX_STATE_SUSPENDED;
        endcase
    end

    // Filter decode on {pass-mcast, accept-any, inverse, hash-only, hash-sel}
    always_comb begin
        logic [4:0] f;
        f = {opmode_r[mmoc_pkg::PASS_MCAST_BIT],
             opmode_r[mmoc_pkg::ACCEPT_ANY_BIT], filt_r[2], filt_r[1],
             filt_r[0]};
        if (f == 5'h00) begin
            filter_mode = mmoc_pkg::MMOC_FILT_PERFECT16; // RULE17
        end else if (f == 5'h01) begin
            filter_mode = mmoc_pkg::MMOC_FILT_HASH_ONE; // RULE17
        end else if (f == 5'h03) begin
            filter_mode = mmoc_pkg::MMOC_FILT_HASH_ALL; // RULE17
        end else if (f == 5'h04) begin
            filter_mode = mmoc_pkg::MMOC_FILT_INVERSE; // RULE17
        end else if (f[3:1] == 3'h4 || f == 5'h0B) begin
            filter_mode = mmoc_pkg::MMOC_FILT_PROMISC; // RULE17
        end else if (f[4:1] == 4'h8 || f == 5'h13) begin
            filter_mode = mmoc_pkg::MMOC_FILT_ALL_MCAST; // RULE17
        end else begin
            filter_mode = mmoc_pkg::MMOC_FILT_UNDEFINED;
        end
    end

    // match: [0] perfect table hit, [1] hash hit, [2] single perfect, [3] bad
    always_comb begin
        logic hit;
        logic phys_hit;
        hit = 1'b0;
        phys_hit = filt_r[0] ? (filt_r[1] ? frame_in.match[1]
                                          : frame_in.match[2])
                             : frame_in.match[0]; // RULE11
        case (filter_mode)
            mmoc_pkg::MMOC_FILT_PERFECT16: hit = frame_in.match[0];
            mmoc_pkg::MMOC_FILT_HASH_ONE:
                hit = frame_in.is_multicast ? frame_in.match[1]
                                            : frame_in.match[2];
            mmoc_pkg::MMOC_FILT_HASH_ALL: hit = frame_in.match[1];
            mmoc_pkg::MMOC_FILT_INVERSE: hit = !frame_in.match[0]; // RULE4
            mmoc_pkg::MMOC_FILT_PROMISC: hit = 1'b1; // RULE2
            mmoc_pkg::MMOC_FILT_ALL_MCAST:
                hit = frame_in.is_multicast || phys_hit; // RULE1
            default: hit = 1'b0;
        endcase
        verdict.address_match = hit; // RULE18
        verdict.accept = frame_in.valid
            && (hit || opmode_r[mmoc_pkg::RECEIVE_ALL_BIT]) // RULE18
            && (!frame_in.match[3]
                || opmode_r[mmoc_pkg::KEEP_BAD_BIT]); // RULE5
    end

    assign keep_bad_frames = opmode_r[mmoc_pkg::KEEP_BAD_BIT]; // RULE5

    // Threshold selection
    always_comb begin
        logic slow;
        slow = !opmode_r[mmoc_pkg::PORT_SELECT_BIT]
            || opmode_r[mmoc_pkg::SLOW_THRESHOLD_BIT];
        tx_store_forward = opmode_r[mmoc_pkg::STORE_FORWARD_BIT]; // RULE12
        case (opmode_r[mmoc_pkg::THRESHOLD_LO_BIT +: 2])
            2'h0: tx_threshold_bytes = slow ? mmoc_pkg::THR_SLOW_0
                                            : mmoc_pkg::THR_FAST_0; // RULE12
            2'h1: tx_threshold_bytes = slow ? mmoc_pkg::THR_SLOW_1
                                            : mmoc_pkg::THR_FAST_1; // RULE12
            2'h2: tx_threshold_bytes = slow ? mmoc_pkg::THR_SLOW_2
                                            : mmoc_pkg::THR_FAST_2; // RULE12
            default: tx_threshold_bytes = slow ? mmoc_pkg::THR_SLOW_3
                                               : mmoc_pkg::THR_FAST_3;
        endcase
    end

    // Port, rate and loopback; code 11 loopback is treated as normal
    always_comb begin
        logic ps;
        logic slow_t;
        logic [1:0] lb;
        ps = opmode_r[mmoc_pkg::PORT_SELECT_BIT];
        slow_t = opmode_r[mmoc_pkg::SLOW_THRESHOLD_BIT];
        lb = opmode_r[mmoc_pkg::LOOPBACK_LO_BIT +: 2];
        port_cfg.coding_on = ps && !slow_t
            && opmode_r[mmoc_pkg::CODING_BIT]; // RULE14
        port_cfg.randomizer_on = port_cfg.coding_on
            && opmode_r[mmoc_pkg::RANDOMIZER_BIT]; // RULE14
        if (!ps) begin
            port_cfg.port = mmoc_pkg::MMOC_PORT_SERIAL; // RULE13
        end else if (port_cfg.coding_on) begin
            port_cfg.port = mmoc_pkg::MMOC_PORT_SYMBOL; // RULE14
        end else begin
            port_cfg.port = mmoc_pkg::MMOC_PORT_MII; // RULE13
        end
        port_cfg.rate_100m = ps && !slow_t; // RULE13
        port_cfg.loop_internal = lb == 2'h1; // RULE15
        port_cfg.loop_external = lb == 2'h2; // RULE15
        // Symbols still leave on the symbol port during internal loop
        port_cfg.mii_txen_block = port_cfg.loop_internal
            && port_cfg.port == mmoc_pkg::MMOC_PORT_MII; // RULE16
    end

    // Backoff hold and post-carrier gap counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_cnt_r <= 12'h000;
            carrier_seen_r <= 1'b0;
        end else if (clk_en) begin
            carrier_seen_r <= carrier_sense;
            if (carrier_sense) begin
                gap_cnt_r <= port_cfg.rate_100m ? mmoc_pkg::IFS_100M_CYCLES
                                                : mmoc_pkg::IFS_10M_CYCLES;
            end else if (gap_cnt_r != 12'h000) begin
                gap_cnt_r <= gap_cnt_r - 12'h001; // RULE3
            end
        end
    end

    assign backoff_run = !(opmode_r[mmoc_pkg::BACKOFF_HOLD_BIT]
        && carrier_sense); // RULE3
    assign tx_gap_done = !carrier_sense && !carrier_seen_r
        && gap_cnt_r == 12'h000; // RULE3
endmodule : mmoc_regs
`default_nettype wire

// file: mmoc_regs_assertions.sv
// Concurrent checks on the mmoc_regs ports: bus, receive, decode, gating.
// Assumes one clock domain; bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module mmoc_regs_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic desc_fetch_done,
    input wire logic desc_owned,
    input wire logic carrier_sense,
    input wire logic backoff_run,
    input wire logic tx_gap_done,
    input wire logic rx_buf_unavail_set,
    input wire logic [2:0] rx_state,
    input wire logic [10:0] tx_threshold_bytes,
    input wire logic tx_store_forward,
    input wire mmoc_pkg::mmoc_port_cfg_t port_cfg,
    input wire logic [16:0] status_bits,
    input wire logic [16:0] int_pending
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence seq_req;
        cyc_i && stb_i && !ack_o && clk_en;
    endsequence
    sequence seq_start;
        seq_req ##0 (we_i && adr_i == mmoc_pkg::OPMODE_OFFSET && sel_i[0]
            && dat_i[1] && rx_state == mmoc_pkg::RX_STATE_STOPPED);
    endsequence
    sequence seq_not_owned;
        rx_state == mmoc_pkg::RX_STATE_FETCH && desc_fetch_done && !desc_owned;
    endsequence
    chk_ack_once: assert property (seq_req |=> ack_o ##1 !ack_o)
        else $error("ack missing or longer than one cycle");
    chk_rx_start: assert property (
        seq_start |=> ##[0:1] rx_state == mmoc_pkg::RX_STATE_FETCH)
        else $error("receive start did not fetch");
    chk_rx_unavail: assert property (
        seq_not_owned |-> ##[1:2] rx_buf_unavail_set)
        else $error("buffer unavailable flag not raised");
    chk_rx_suspend: assert property (
        seq_not_owned |=> ##[0:1] rx_state == mmoc_pkg::RX_STATE_SUSPENDED)
        else $error("receive did not suspend");
    chk_backoff_free: assert property (!carrier_sense |-> backoff_run)
        else $error("backoff paused without carrier");
    chk_gap_wait: assert property (
        $fell(carrier_sense) |-> !tx_gap_done [*8])
        else $error("gap ended too early");
    chk_thresh_set: assert property (!tx_store_forward |->
        tx_threshold_bytes inside {11'h048, 11'h060, 11'h080, 11'h0A0,
        11'h100, 11'h200, 11'h400})
        else $error("threshold outside table");
    chk_mii_txen: assert property (port_cfg.mii_txen_block ==
        (port_cfg.loop_internal && port_cfg.port == mmoc_pkg::MMOC_PORT_MII))
        else $error("transmit enable hold wrong in internal loopback");
    chk_int_gate: assert property (
        (int_pending & ~status_bits) == 17'h0)
        else $error("interrupt without status");
endmodule : mmoc_regs_assertions
`default_nettype wire

// file: testbench.sv
// Self-checking bench for mmoc_regs against a model kept in variables.
// Assumes the package, design and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, soft_rst = 1'h0;
    logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, setup_load = 1'h0;
    logic desc_fetch_done = 1'h0, desc_owned = 1'h0;
    logic rx_frame_active = 1'h0, carrier_sense = 1'h0;
    logic ack_o, backoff_run, tx_gap_done, rx_buf_unavail_set;
    logic tx_store_forward, keep_bad_frames;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, opm, ien, rd, m;
    logic [2:0] setup_filter_bits = 3'h0, filt, rx_state;
    logic [10:0] tx_threshold_bytes, thr;
    logic [16:0] status_bits = 17'h00000, int_pending, gate;
    mmoc_pkg::mmoc_frame_t frame_in = '0;
    mmoc_pkg::mmoc_verdict_t verdict;
    mmoc_pkg::mmoc_port_cfg_t port_cfg;
    int error_cnt = 0, comparisons = 0, cycles = 0, n;
    localparam logic [31:0] RO = mmoc_pkg::OPMODE_RO_MASK;
    localparam logic [7:0] OPM = mmoc_pkg::OPMODE_OFFSET;
    localparam logic [7:0] IEN = mmoc_pkg::INTEN_OFFSET;
    localparam logic [10:0] TSL [4] = '{11'h048, 11'h060, 11'h080, 11'h0A0};
    // {pm, pr, filter bits, match, multicast, valid, accept}
    localparam logic [11:0] FC [9] = '{12'h403, 12'h807, 12'h802, 12'h00B,
        12'h20A, 12'h203, 12'h193, 12'h0A3, 12'h082};

    mmoc_regs dut (.core_clk, .rst, .clk_en, .soft_rst, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .setup_load,
        .setup_filter_bits, .desc_fetch_done, .desc_owned, .rx_frame_active,
        .frame_in, .verdict, .carrier_sense, .backoff_run, .tx_gap_done,
        .rx_buf_unavail_set, .rx_state, .tx_threshold_bytes,
        .tx_store_forward, .port_cfg, .keep_bad_frames, .status_bits,
        .int_pending);

    always #2 core_clk = ~core_clk;

    // Whole run needs about 2700 cycles; the ceiling leaves ample margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single classic cycle; the model follows only once ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(negedge core_clk); while (ack_o !== 1'h1);
        @(posedge core_clk);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (w && a == OPM) opm = (opm & ~(m & ~RO)) | (d & m & ~RO);
        if (w && a == IEN) ien = (ien & ~m) | (d & m & mmoc_pkg::INTEN_MASK);
    endtask : wb

    task automatic rchk(input logic [7:0] a);
        wb(1'h0, a, 32'h0, 4'hF);
        if (a == OPM) chk(rd, (opm & ~RO) | {27'h0, filt[2], 1'h0, filt[1],
            1'h0, filt[0]});
        else chk(rd, a == IEN ? ien : 32'h0);
    endtask : rchk

    initial begin
        void'($urandom(32'hD3D1));
        opm = mmoc_pkg::OPMODE_RESET;
        ien = 32'h0;
        filt = 3'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'h0;
        rchk(OPM);
        rchk(IEN);
        rchk(8'h20);
        for (int i = 0; i < 16; i++) begin
            wb(1'h1, OPM, $urandom() & 32'hFFFFFFFD, 4'hF);
            rchk(OPM);
            thr = opm[22] || !opm[18] ? TSL[opm[15:14]]
                : 11'(11'h080 << opm[15:14]);
            if (!opm[21]) chk(tx_threshold_bytes, thr);
            chk(tx_store_forward, opm[21]);
            chk(keep_bad_frames, opm[3]);
            chk(port_cfg.loop_internal, opm[11:10] == 2'h1);
            chk(port_cfg.loop_external, opm[11:10] == 2'h2);
            if (!opm[18] && !opm[22]) chk(port_cfg.port, 2'h0);
            if (opm[18] && !opm[23]) chk({port_cfg.port, port_cfg.rate_100m},
                {2'h1, !opm[22]});
            if (opm[18] && !opm[22] && opm[23]) chk({port_cfg.port,
                port_cfg.randomizer_on}, {2'h2, opm[24]});
            chk(port_cfg.mii_txen_block, opm[11:10] == 2'h1 && opm[18]
                && (opm[22] || !opm[23]));
        end
        wb(1'h1, OPM, 32'h00000020, 4'hF);
        carrier_sense <= 1'h1;
        repeat (3) @(posedge core_clk);
        chk(backoff_run, 1'h0);
        carrier_sense <= 1'h0;
        n = 0;
        while (tx_gap_done !== 1'h1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        chk(n >= 2398 && n <= 2402, 1'h1);
        foreach (FC[i]) begin
            @(posedge core_clk);
            setup_load <= 1'h1;
            setup_filter_bits <= FC[i][9:7];
            frame_in <= mmoc_pkg::mmoc_frame_t'(FC[i][6:1]);
            @(posedge core_clk);
            setup_load <= 1'h0;
            filt = FC[i][9:7];
            wb(1'h1, OPM, {24'h0, FC[i][11:10], 6'h0}, 4'hF);
            rchk(OPM);
            chk(verdict.accept, FC[i][0]);
            chk(verdict.address_match, FC[i][0]);
        end
        frame_in <= 6'h21;
        wb(1'h1, OPM, 32'h00000048, 4'hF);
        chk(verdict.accept, 1'h1);
        for (int i = 0; i < 8; i++) begin
            wb(1'h1, IEN, $urandom(), 4'hF);
            rchk(IEN);
            status_bits <= 17'($urandom());
            @(posedge core_clk);
            @(negedge core_clk);
            gate = (ien[16] ? 17'(mmoc_pkg::NORMAL_SRC_MASK) : 17'h0)
                | (ien[15] ? 17'(mmoc_pkg::ABNORMAL_SRC_MASK) : 17'h0);
            chk(int_pending, status_bits & ien[16:0] & gate);
        end
        wb(1'h1, OPM, 32'h00040000, 4'hF);
        @(posedge core_clk);
        soft_rst <= 1'h1;
        @(posedge core_clk);
        soft_rst <= 1'h0;
        opm = mmoc_pkg::OPMODE_RESET | 32'h00040000;
        ien = 32'h0;
        filt = 3'h0;
        rchk(IEN);
        rchk(OPM);
        wb(1'h1, OPM, 32'h00000002, 4'hF);
        for (n = 0; n < 4 && rx_state !== 3'h1; n++) @(negedge core_clk);
        chk(rx_state, mmoc_pkg::RX_STATE_FETCH);
        @(posedge core_clk);
        desc_fetch_done <= 1'h1;
        @(posedge core_clk);
        desc_fetch_done <= 1'h0;
        for (n = 0; n < 4 && rx_buf_unavail_set !== 1'h1; n++)
            @(negedge core_clk);
        chk(rx_buf_unavail_set, 1'h1);
        chk(rx_state, mmoc_pkg::RX_STATE_SUSPENDED);
        @(posedge core_clk);
        rx_frame_active <= 1'h1;
        wb(1'h1, OPM, 32'h0, 4'hF);
        repeat (3) @(posedge core_clk);
        chk(rx_state == mmoc_pkg::RX_STATE_STOPPED, 1'h0);
        rx_frame_active <= 1'h0;
        repeat (3) @(posedge core_clk);
        chk(rx_state, mmoc_pkg::RX_STATE_STOPPED);
        results();
    end
endmodule : testbench

bind mmoc_regs mmoc_regs_assertions u_chk (.core_clk, .rst, .clk_en, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .desc_fetch_done,
    .desc_owned, .carrier_sense, .backoff_run, .tx_gap_done,
    .rx_buf_unavail_set, .rx_state, .tx_threshold_bytes, .tx_store_forward,
    .port_cfg, .status_bits, .int_pending);
`default_nettype wire
